// [hdl/rsid_map.svh]
// opcode, memory and pointer constants of the radio strobe instruction decoder
`ifndef RSID_MAP_SVH
`define RSID_MAP_SVH

// program-memory radio strobes
`define RSID_OP_FLUSH_RECEIVE      8'hc6
`define RSID_OP_FLUSH_TRANSMIT     8'hc7
`define RSID_OP_SEND_ACK_CLEAR     8'hc8
`define RSID_OP_SEND_ACK_PENDING   8'hc9
// loop label instruction
`define RSID_OP_LABEL              8'hba
// immediate instructions
`define RSID_OP_IMM_TX_SYNTH_CAL   8'he1
`define RSID_OP_IMM_RECEIVE_ON     8'he2
`define RSID_OP_IMM_TRANSMIT_ON    8'he3
`define RSID_OP_IMM_GATED_TX       8'he4
`define RSID_OP_IMM_RADIO_OFF      8'he5
`define RSID_OP_IMM_FLUSH_RECEIVE  8'he6
`define RSID_OP_IMM_FLUSH_TRANSMIT 8'he7
`define RSID_OP_IMM_RUN            8'hfe
`define RSID_OP_IMM_HALT           8'hff

// instruction memory geometry
`define RSID_IMEM_DEPTH            24
`define RSID_PTR_ZERO              5'h00
`define RSID_PTR_ONE               5'h01
`define RSID_PTR_LAST              5'h17
`define RSID_PTR_FULL              5'h18
`define RSID_OP_ZERO               8'h00

`endif

// [hdl/rsid_pkg.sv]
// types shared by the radio strobe instruction decoder
package rsid_pkg;

    typedef enum logic [3:0] {
        no_cmd               = 4'h0,
        flush_receive_cmd    = 4'h1,
        flush_transmit_cmd   = 4'h2,
        send_ack_clear_cmd   = 4'h3,
        send_ack_pending_cmd = 4'h4,
        tx_synth_cal_cmd     = 4'h5,
        receive_on_cmd       = 4'h6,
        transmit_on_cmd      = 4'h7,
        gated_transmit_cmd   = 4'h8,
        radio_off_cmd        = 4'h9
    } rsid_radio_cmd_t;

    typedef enum logic [0:0] {
        RSID_ST_READY = 1'b0,
        RSID_ST_WAIT  = 1'b1
    } rsid_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rsid_cpu_wr_t;

    typedef struct packed {
        logic            req;
        rsid_radio_cmd_t cmd;
    } rsid_radio_req_t;

    typedef struct packed {
        logic            is_imm;
        logic            is_strobe;
        logic            is_halt;
        logic            is_run;
        logic            is_label;
        rsid_radio_cmd_t cmd;
    } rsid_decode_t;

endpackage

// [hdl/rsid_opcode_decode.sv]
// opcode decoder of the radio strobe instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "rsid_map.svh"

module rsid_opcode_decode (
    input  wire logic [7:0]          opcode,
    output rsid_pkg::rsid_decode_t   dec
);
    // classify one opcode and pick its radio command
    always_comb begin
        dec = '0;
        dec.cmd = rsid_pkg::no_cmd;
        case (opcode)
            `RSID_OP_FLUSH_RECEIVE: begin
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::flush_receive_cmd;
            end
            `RSID_OP_FLUSH_TRANSMIT: begin
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::flush_transmit_cmd;
            end
            `RSID_OP_SEND_ACK_CLEAR: begin
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::send_ack_clear_cmd;
            end
            `RSID_OP_SEND_ACK_PENDING: begin
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::send_ack_pending_cmd;
            end
            `RSID_OP_LABEL: begin
                dec.is_label = 1'b1;
            end
            `RSID_OP_IMM_TX_SYNTH_CAL: begin
                dec.is_imm = 1'b1;
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::tx_synth_cal_cmd;
            end
            `RSID_OP_IMM_RECEIVE_ON: begin
                dec.is_imm = 1'b1;
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::receive_on_cmd;
            end
            `RSID_OP_IMM_TRANSMIT_ON: begin
                dec.is_imm = 1'b1;
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::transmit_on_cmd;
            end
            `RSID_OP_IMM_GATED_TX: begin
                dec.is_imm = 1'b1;
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::gated_transmit_cmd;
            end
            `RSID_OP_IMM_RADIO_OFF: begin
                dec.is_imm = 1'b1;
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::radio_off_cmd;
            end
            `RSID_OP_IMM_FLUSH_RECEIVE: begin
                dec.is_imm = 1'b1;
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::flush_receive_cmd;
            end
            `RSID_OP_IMM_FLUSH_TRANSMIT: begin
                dec.is_imm = 1'b1;
                dec.is_strobe = 1'b1;
                dec.cmd = rsid_pkg::flush_transmit_cmd;
            end
            `RSID_OP_IMM_RUN: begin
                dec.is_imm = 1'b1;
                dec.is_run = 1'b1;
            end
            `RSID_OP_IMM_HALT: begin
                dec.is_imm = 1'b1;
                dec.is_halt = 1'b1;
            end
            default: begin
                dec.is_strobe = 1'b0;
            end
        endcase
    end

endmodule // rsid_opcode_decode
`default_nettype wire

// [hdl/rsid_core.sv]
// radio strobe instruction decoder: program store, execution and radio handshake
`timescale 1ns/1ps
`default_nettype none
`include "rsid_map.svh"

// Overview of operation
// - program 0xC6 strobes radio receive flush
// - program 0xC7 strobes radio transmit flush
// - program 0xC8 sends ack, pending cleared
// - program 0xC9 sends ack, pending set
// - each strobe stalls until radio acknowledges
// - immediate 0xFF halts the program
// - halt clears memory and loop label
// - halt raises program stopped flag
// - immediate 0xFE restarts program from zero
// - immediate 0xE1 calibrates synthesizer for transmit
// - immediate 0xE2 turns receive on
// - immediate 0xE3 enables transmit
// - immediate 0xE4 issues channel-gated transmit
// - immediate 0xE5 turns radio off
// - immediate 0xE6 flushes receive queue
// - immediate 0xE7 flushes transmit queue
// - halt zeroes counter and write pointer
module rsid_core (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire rsid_pkg::rsid_cpu_wr_t    cpu_wr,
    input  wire logic                      radio_ack,
    output logic                           cpu_ready,
    output rsid_pkg::rsid_radio_req_t      radio_req,
    output logic                           program_stopped_flag,
    output logic                           running,
    output logic [4:0]                     pc,
    output logic [4:0]                     wr_ptr,
    output logic                           label_valid,
    output logic [4:0]                     label_pos
);
    rsid_pkg::rsid_state_t      state_ff;
    rsid_pkg::rsid_state_t      nxt_state;
    rsid_pkg::rsid_radio_req_t  radio_req_ff;
    rsid_pkg::rsid_decode_t     dec_cpu;
    rsid_pkg::rsid_decode_t     dec_prog;
    logic                       cpu_ready_ff;
    logic                       stopped_ff;
    logic                       running_ff;
    logic [4:0]                 pc_ff;
    logic [4:0]                 wr_ptr_ff;
    logic                       label_valid_ff;
    logic [4:0]                 label_ff;
    logic [7:0]                 instr_mem_ff [`RSID_IMEM_DEPTH];
    logic [7:0]                 prog_op;
    logic                       cpu_take;
    logic                       imm_go;
    logic                       store_go;
    logic                       prog_go;
    logic                       halt_go;
    logic                       run_go;
    logic                       issue_imm;
    logic                       issue_prog;

    // decoders for the written byte and the fetched instruction
    rsid_opcode_decode u_dec_cpu (
        .opcode (cpu_wr.data),
        .dec    (dec_cpu)
    );

    rsid_opcode_decode u_dec_prog (
        .opcode (prog_op),
        .dec    (dec_prog)
    );

    // fetch and step qualifiers
    assign prog_op    = (pc_ff < `RSID_PTR_FULL) ? instr_mem_ff[pc_ff] : `RSID_OP_ZERO;
    assign cpu_take   = cpu_wr.valid && cpu_ready_ff;
    assign imm_go     = cpu_take && dec_cpu.is_imm;
    assign store_go   = cpu_take && !dec_cpu.is_imm && (wr_ptr_ff != `RSID_PTR_FULL);
    assign halt_go    = imm_go && dec_cpu.is_halt;
    assign run_go     = imm_go && dec_cpu.is_run;
    assign prog_go    = (state_ff == rsid_pkg::RSID_ST_READY) && running_ff && !imm_go
                        && (pc_ff != wr_ptr_ff);
    assign issue_imm  = imm_go && dec_cpu.is_strobe;
    assign issue_prog = prog_go && dec_prog.is_strobe;

    // handshake state: wait holds off the next instruction
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rsid_pkg::RSID_ST_READY: begin
                if (issue_imm || issue_prog) begin
                    nxt_state = rsid_pkg::RSID_ST_WAIT;
                end
            end
            rsid_pkg::RSID_ST_WAIT: begin
                if (radio_ack) begin
                    nxt_state = rsid_pkg::RSID_ST_READY;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff     <= rsid_pkg::RSID_ST_READY;
            cpu_ready_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cpu_ready_ff <= (nxt_state == rsid_pkg::RSID_ST_READY);
        end
    end

    // radio request: held with its command until acknowledged
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            radio_req_ff.req <= 1'b0;
            radio_req_ff.cmd <= rsid_pkg::no_cmd;
        end else if (issue_imm) begin
            radio_req_ff.req <= 1'b1;
            radio_req_ff.cmd <= dec_cpu.cmd;
        end else if (issue_prog) begin
            radio_req_ff.req <= 1'b1;
            radio_req_ff.cmd <= dec_prog.cmd;
        end else if (state_ff == rsid_pkg::RSID_ST_WAIT && radio_ack) begin
            radio_req_ff.req <= 1'b0;
            radio_req_ff.cmd <= rsid_pkg::no_cmd;
        end
    end

    // run control
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            running_ff <= 1'b0;
        end else if (halt_go) begin
            running_ff <= 1'b0;
        end else if (run_go) begin
            running_ff <= 1'b1;
        end
    end

    // program counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pc_ff <= `RSID_PTR_ZERO;
        end else if (halt_go || run_go) begin
            pc_ff <= `RSID_PTR_ZERO;
        end else if (prog_go) begin
            pc_ff <= pc_ff + `RSID_PTR_ONE;
        end
    end

    // write pointer of the stored program
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_ff <= `RSID_PTR_ZERO;
        end else if (halt_go) begin
            wr_ptr_ff <= `RSID_PTR_ZERO;
        end else if (store_go) begin
            wr_ptr_ff <= wr_ptr_ff + `RSID_PTR_ONE;
        end
    end

    // instruction memory, one process per entry
    for (genvar gi = 0; gi < `RSID_IMEM_DEPTH; gi++) begin : g_imem
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                instr_mem_ff[gi] <= `RSID_OP_ZERO;
            end else if (halt_go) begin
                instr_mem_ff[gi] <= `RSID_OP_ZERO;
            end else if (store_go && wr_ptr_ff == 5'(gi)) begin
                instr_mem_ff[gi] <= cpu_wr.data;
            end
        end
    end

    // loop label: next instruction, or this one at the last entry
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            label_valid_ff <= 1'b0;
            label_ff       <= `RSID_PTR_ZERO;
        end else if (halt_go) begin
            label_valid_ff <= 1'b0;
        end else if (prog_go && dec_prog.is_label) begin
            label_valid_ff <= 1'b1;
            label_ff       <= (pc_ff == `RSID_PTR_LAST) ? pc_ff : pc_ff + `RSID_PTR_ONE;
        end
    end

    // stopped flag pulse
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stopped_ff <= 1'b0;
        end else begin
            stopped_ff <= halt_go;
        end
    end

    assign cpu_ready            = cpu_ready_ff;
    assign radio_req            = radio_req_ff;
    assign program_stopped_flag = stopped_ff;
    assign running              = running_ff;
    assign pc                   = pc_ff;
    assign wr_ptr               = wr_ptr_ff;
    assign label_valid          = label_valid_ff;
    assign label_pos            = label_ff;

    // program strobes reach the radio one cycle after fetch
    property p_prog_flush_rx;
        @(posedge core_clk) disable iff (!rst_n)
        prog_go && prog_op == 8'hc6
            |=> radio_req.req && radio_req.cmd == rsid_pkg::flush_receive_cmd;
    endproperty
    a_prog_flush_rx: assert property (p_prog_flush_rx)
        else $error("0xc6 strobe missing");

    property p_prog_flush_tx;
        @(posedge core_clk) disable iff (!rst_n)
        prog_go && prog_op == 8'hc7
            |=> radio_req.req && radio_req.cmd == rsid_pkg::flush_transmit_cmd;
    endproperty
    a_prog_flush_tx: assert property (p_prog_flush_tx)
        else $error("0xc7 strobe missing");

    property p_prog_ack_clr;
        @(posedge core_clk) disable iff (!rst_n)
        prog_go && prog_op == 8'hc8
            |=> radio_req.req && radio_req.cmd == rsid_pkg::send_ack_clear_cmd;
    endproperty
    a_prog_ack_clr: assert property (p_prog_ack_clr)
        else $error("0xc8 strobe missing");

    property p_prog_ack_pend;
        @(posedge core_clk) disable iff (!rst_n)
        prog_go && prog_op == 8'hc9
            |=> radio_req.req && radio_req.cmd == rsid_pkg::send_ack_pending_cmd;
    endproperty
    a_prog_ack_pend: assert property (p_prog_ack_pend)
        else $error("0xc9 strobe missing");

    // no step and no new request while the radio has not acknowledged
    property p_stall;
        @(posedge core_clk) disable iff (!rst_n)
        radio_req.req && !radio_ack
            |=> radio_req.req && $stable(pc) && $stable(radio_req.cmd) && !cpu_ready;
    endproperty
    a_stall: assert property (p_stall)
        else $error("request dropped before acknowledge");

    property p_halt;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'hff |=> !running && pc == 5'h00;
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop program");

    property p_halt_clear;
        @(posedge core_clk) disable iff (!rst_n)
        halt_go |=> wr_ptr == 5'h00 && !label_valid && instr_mem_ff[0] == 8'h00;
    endproperty
    a_halt_clear: assert property (p_halt_clear)
        else $error("halt left memory or label");

    property p_stop_flag;
        @(posedge core_clk) disable iff (!rst_n)
        halt_go |=> program_stopped_flag ##1 !program_stopped_flag;
    endproperty
    a_stop_flag: assert property (p_stop_flag)
        else $error("stopped flag not a single pulse");

    property p_run;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'hfe |=> running && pc == 5'h00;
    endproperty
    a_run: assert property (p_run) else $error("run did not restart at zero");

    property p_imm_txcal;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'he1
            |=> radio_req.req && radio_req.cmd == rsid_pkg::tx_synth_cal_cmd;
    endproperty
    a_imm_txcal: assert property (p_imm_txcal) else $error("0xe1 command missing");

    property p_imm_rxon;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'he2
            |=> radio_req.req && radio_req.cmd == rsid_pkg::receive_on_cmd;
    endproperty
    a_imm_rxon: assert property (p_imm_rxon) else $error("0xe2 command missing");

    property p_imm_txon;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'he3
            |=> radio_req.req && radio_req.cmd == rsid_pkg::transmit_on_cmd;
    endproperty
    a_imm_txon: assert property (p_imm_txon) else $error("0xe3 command missing");

    property p_imm_gated;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'he4
            |=> radio_req.req && radio_req.cmd == rsid_pkg::gated_transmit_cmd;
    endproperty
    a_imm_gated: assert property (p_imm_gated) else $error("0xe4 command missing");

    property p_imm_off;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'he5
            |=> radio_req.req && radio_req.cmd == rsid_pkg::radio_off_cmd;
    endproperty
    a_imm_off: assert property (p_imm_off) else $error("0xe5 command missing");

    property p_imm_frx;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'he6
            |=> radio_req.req && radio_req.cmd == rsid_pkg::flush_receive_cmd;
    endproperty
    a_imm_frx: assert property (p_imm_frx) else $error("0xe6 command missing");

    property p_imm_ftx;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_take && cpu_wr.data == 8'he7
            |=> radio_req.req && radio_req.cmd == rsid_pkg::flush_transmit_cmd;
    endproperty
    a_imm_ftx: assert property (p_imm_ftx) else $error("0xe7 command missing");

    property p_halt_ptrs;
        @(posedge core_clk) disable iff (!rst_n)
        halt_go ##1 !cpu_take |=> pc == 5'h00 && wr_ptr == 5'h00;
    endproperty
    a_halt_ptrs: assert property (p_halt_ptrs)
        else $error("pointers not zero after halt");

    property p_imm_not_stored;
        @(posedge core_clk) disable iff (!rst_n)
        imm_go && !dec_cpu.is_halt |=> $stable(wr_ptr);
    endproperty
    a_imm_not_stored: assert property (p_imm_not_stored)
        else $error("immediate was stored");

    // acknowledge ends the request and frees the writer
    property p_ack_release;
        @(posedge core_clk) disable iff (!rst_n)
        radio_req.req && radio_ack
            |=> !radio_req.req && cpu_ready && radio_req.cmd == rsid_pkg::no_cmd;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("acknowledge did not end request");

    property p_store_step;
        @(posedge core_clk) disable iff (!rst_n)
        store_go |=> wr_ptr == $past(wr_ptr) + 5'h01;
    endproperty
    a_store_step: assert property (p_store_step)
        else $error("stored byte not appended");

    property p_imm_no_step;
        @(posedge core_clk) disable iff (!rst_n)
        imm_go && !dec_cpu.is_run && !dec_cpu.is_halt |=> $stable(pc);
    endproperty
    a_imm_no_step: assert property (p_imm_no_step)
        else $error("immediate moved the counter");

endmodule // rsid_core
`default_nettype wire

// [verif/rsid_radio_model.sv]
// behavioural radio controller that answers the decoder's command requests
`timescale 1ns/1ps
`default_nettype none
module rsid_radio_model (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire rsid_pkg::rsid_radio_req_t radio_req,
    input  wire logic [3:0]                ack_delay,
    input  wire logic                      cca_clear,
    output logic                           radio_ack,
    output logic                           tx_active
);
    logic [3:0] wait_ff;

    // acknowledge each request ack_delay+1 cycles after it rises, one-cycle pulse
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_ff <= 4'h0;
            radio_ack <= 1'b0;
        end else if (radio_req.req && !radio_ack) begin
            if (wait_ff == ack_delay) begin
                radio_ack <= 1'b1;
                wait_ff <= 4'h0;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end else begin
            radio_ack <= 1'b0;
        end
    end

    // transmitter state, gated start only on a clear channel
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_active <= 1'b0;
        end else if (radio_req.req && radio_ack) begin
            case (radio_req.cmd)
                rsid_pkg::transmit_on_cmd:    tx_active <= 1'b1;
                rsid_pkg::gated_transmit_cmd: tx_active <= cca_clear;
                rsid_pkg::radio_off_cmd:      tx_active <= 1'b0;
                default:                      tx_active <= tx_active;
            endcase
        end
    end
endmodule // rsid_radio_model
`default_nettype wire

// [verif/tb.sv]
// self-checking testbench of the radio strobe instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "rsid_map.svh"
module tb;
    logic                      core_clk;
    logic                      rst_n;
    rsid_pkg::rsid_cpu_wr_t    cpu_wr;
    logic                      radio_ack;
    logic                      cpu_ready;
    rsid_pkg::rsid_radio_req_t radio_req;
    logic                      program_stopped_flag;
    logic                      running;
    logic [4:0]                pc;
    logic [4:0]                wr_ptr;
    logic                      label_valid;
    logic [4:0]                label_pos;
    logic [3:0]                ack_delay;
    logic                      cca_clear;
    logic                      tx_active;
    int                        err_total;
    int                        n_tests;

    rsid_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .cpu_wr(cpu_wr), .radio_ack(radio_ack),
        .cpu_ready(cpu_ready), .radio_req(radio_req), .program_stopped_flag(program_stopped_flag),
        .running(running), .pc(pc), .wr_ptr(wr_ptr), .label_valid(label_valid),
        .label_pos(label_pos));
    rsid_radio_model u_radio (.core_clk(core_clk), .rst_n(rst_n), .radio_req(radio_req),
        .ack_delay(ack_delay), .cca_clear(cca_clear), .radio_ack(radio_ack), .tx_active(tx_active));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic mism(string m);
        err_total++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask
    task automatic chk1(logic exp, logic got, string m);
        n_tests++;
        if (got !== exp) mism(m);
    endtask
    task automatic chk5(logic [4:0] exp, logic [4:0] got, string m);
        n_tests++;
        if (got !== exp) mism(m);
    endtask
    task automatic chkc(rsid_pkg::rsid_radio_cmd_t exp, rsid_pkg::rsid_radio_cmd_t got, string m);
        n_tests++;
        if (got !== exp) mism(m);
    endtask

    // offer one byte, hold it until cpu_ready is seen at the taking edge
    task automatic wr_byte(logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        cpu_wr <= '{valid: 1'b1, data: d};
        @(negedge core_clk);
        while (cpu_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 50) mism("cpu_ready stuck low");
        @(posedge core_clk);
        cpu_wr.valid <= 1'b0;
    endtask

    // one command request: code, stall while pending, release after ack
    task automatic exp_cmd(rsid_pkg::rsid_radio_cmd_t c, string m);
        int n;
        n = 0;
        @(negedge core_clk);
        while (radio_req.req !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        chkc(c, radio_req.cmd, m);
        chk1(1'b0, cpu_ready, "cpu_ready high while pending");
        n = 0;
        while (radio_req.req === 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        chkc(rsid_pkg::no_cmd, radio_req.cmd, "cmd not idle after ack");
        chk1(1'b1, cpu_ready, "cpu_ready low after ack");
    endtask

    task automatic t_reset();
        @(negedge core_clk);
        chk1(1'b0, radio_req.req, "req after reset");
        chk5(5'h00, wr_ptr, "wr_ptr after reset");
        chk1(1'b0, cpu_ready, "ready too early");
        @(negedge core_clk);
        chk1(1'b1, cpu_ready, "ready not raised");
    endtask

    // every immediate radio command, with a different ack wait each time
    task automatic t_immediates();
        logic [7:0] ops[7] = '{`RSID_OP_IMM_TX_SYNTH_CAL, `RSID_OP_IMM_RECEIVE_ON,
            `RSID_OP_IMM_TRANSMIT_ON, `RSID_OP_IMM_GATED_TX, `RSID_OP_IMM_RADIO_OFF,
            `RSID_OP_IMM_FLUSH_RECEIVE, `RSID_OP_IMM_FLUSH_TRANSMIT};
        rsid_pkg::rsid_radio_cmd_t cmds[7] = '{rsid_pkg::tx_synth_cal_cmd,
            rsid_pkg::receive_on_cmd, rsid_pkg::transmit_on_cmd, rsid_pkg::gated_transmit_cmd,
            rsid_pkg::radio_off_cmd, rsid_pkg::flush_receive_cmd, rsid_pkg::flush_transmit_cmd};
        for (int i = 0; i < 7; i++) begin
            ack_delay <= 4'(i);
            wr_byte(ops[i]);
            if (i < 4) exp_cmd(cmds[i], "imm cmd");
            else exp_cmd(cmds[i], "imm cmd");
            chk5(5'h00, wr_ptr, "immediate stored");
            if (i == 2) chk1(1'b1, tx_active, "transmit not on");
            if (i == 3) chk1(1'b0, tx_active, "gated start on busy channel");
        end
    endtask

    // stored strobes run in order, twice, the second run a restart from 0
    task automatic t_program();
        rsid_pkg::rsid_radio_cmd_t cmds[4] = '{rsid_pkg::flush_receive_cmd,
            rsid_pkg::flush_transmit_cmd, rsid_pkg::send_ack_clear_cmd,
            rsid_pkg::send_ack_pending_cmd};
        ack_delay <= 4'h3;
        wr_byte(`RSID_OP_FLUSH_RECEIVE);
        wr_byte(`RSID_OP_FLUSH_TRANSMIT);
        wr_byte(`RSID_OP_SEND_ACK_CLEAR);
        wr_byte(`RSID_OP_SEND_ACK_PENDING);
        @(negedge core_clk);
        chk5(5'h04, wr_ptr, "program not stored");
        chk1(1'b0, radio_req.req, "stored byte executed");
        for (int p = 0; p < 2; p++) begin
            wr_byte(`RSID_OP_IMM_RUN);
            @(negedge core_clk);
            chk1(1'b1, running, "not running");
            chk5(5'h00, pc, "pc not zero at start");
            for (int k = 0; k < 4; k++) begin
                exp_cmd(cmds[k], "program cmd");
            end
        end
    endtask

    // label then halt: memory, pointers and label cleared, flag pulses
    task automatic t_halt();
        wr_byte(`RSID_OP_LABEL);
        repeat (4) @(negedge core_clk);
        chk1(1'b1, label_valid, "label not set");
        chk5(5'h05, label_pos, "label position");
        wr_byte(`RSID_OP_IMM_HALT);
        @(negedge core_clk);
        chk1(1'b1, program_stopped_flag, "stop flag missing");
        chk1(1'b0, running, "still running");
        chk5(5'h00, pc, "pc after halt");
        chk5(5'h00, wr_ptr, "wr_ptr after halt");
        chk1(1'b0, label_valid, "label kept");
        @(negedge core_clk);
        chk1(1'b0, program_stopped_flag, "stop flag too long");
        wr_byte(`RSID_OP_IMM_RUN);
        repeat (10) begin
            @(negedge core_clk);
            chk1(1'b0, radio_req.req, "old program ran");
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #(30000 * 5);
        mism("watchdog expired");
        wrap_up();
    end

    // reset, then scenarios
    initial begin
        rst_n = 1'b0;
        cpu_wr = '0;
        ack_delay = 4'h0;
        cca_clear = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_immediates();
        t_program();
        t_halt();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
